// >>> include/cpi_link_if.sv
// link between core end and coprocessor end
`timescale 1ns/1ps
`default_nettype none
interface cpi_link_if;
    logic fetch_request_n;
    logic stall_release;
    logic [31:0] instruction_bus;
    logic pass;
    logic abort_kill;
    logic data_request_n;
    logic [31:0] write_data_bus;
    logic [1:0] decode_handshake;
    logic [1:0] execute_handshake;
    logic [31:0] read_data_bus;

    modport core (
        output fetch_request_n,
        output stall_release,
        output instruction_bus,
        output pass,
        output abort_kill,
        output data_request_n,
        output write_data_bus,
        input decode_handshake,
        input execute_handshake,
        input read_data_bus
    );

    modport coproc (
        input fetch_request_n,
        input stall_release,
        input instruction_bus,
        input pass,
        input abort_kill,
        input data_request_n,
        input write_data_bus,
        output decode_handshake,
        output execute_handshake,
        output read_data_bus
    );
endinterface
`default_nettype wire

// >>> include/cpi_pkg.sv
// shared constants, types and helpers of the coprocessor handshake port
package cpi_pkg;
    typedef logic [1:0] cpi_hs_t;
    localparam cpi_hs_t HS_ABSENT = 2'h2;
    localparam cpi_hs_t HS_WAIT = 2'h0;
    localparam cpi_hs_t HS_GO = 2'h1;
    localparam cpi_hs_t HS_LAST = 2'h3;
    localparam int HS_AND_BIT = 1;
    localparam int HS_OR_BIT = 0;

    typedef logic [2:0] cpi_op_t;
    localparam cpi_op_t OP_NOP = 3'h0;
    localparam cpi_op_t OP_LOAD = 3'h1;
    localparam cpi_op_t OP_STORE = 3'h2;
    localparam cpi_op_t OP_MCR = 3'h3;
    localparam cpi_op_t OP_MRC = 3'h4;
    localparam cpi_op_t OP_CDP = 3'h5;

    // instruction word fields, register count, fifo depth and data width
    localparam int OP_LSB = 28;
    localparam int OP_W = 3;
    localparam int CPN_LSB = 8;
    localparam int CPN_W = 4;
    localparam int CNT_LSB = 4;
    localparam int CNT_W = 4;
    localparam int RA_LSB = 0;
    localparam int RB_LSB = 2;
    localparam int RIDX_W = 2;
    localparam int NUM_REGS = 4;
    localparam int FIFO_DEPTH = 32;
    localparam int DATA_W = 32;

    localparam logic [31:0] NOP_WORD = 32'h0000_0000;
    localparam logic [31:0] WORD_STEP = 32'h0000_0004;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

    function automatic cpi_op_t op_of(input logic [31:0] w);
        return w[OP_LSB +: OP_W];
    endfunction

    function automatic logic [CPN_W-1:0] cpn_of(input logic [31:0] w);
        return w[CPN_LSB +: CPN_W];
    endfunction

    function automatic logic [CNT_W-1:0] cnt_of(input logic [31:0] w);
        return w[CNT_LSB +: CNT_W];
    endfunction

    function automatic logic [RIDX_W-1:0] ra_of(input logic [31:0] w);
        return w[RA_LSB +: RIDX_W];
    endfunction

    function automatic logic [RIDX_W-1:0] rb_of(input logic [31:0] w);
        return w[RB_LSB +: RIDX_W];
    endfunction

    // wired combine of several coprocessors on one handshake bus
    function automatic cpi_hs_t hs_merge(input cpi_hs_t a, input cpi_hs_t b);
        cpi_hs_t m;
        m[HS_AND_BIT] = a[HS_AND_BIT] & b[HS_AND_BIT]; // RQ17
        m[HS_OR_BIT] = a[HS_OR_BIT] | b[HS_OR_BIT]; // RQ17
        return m;
    endfunction
endpackage

// >>> logic/cpi_coproc.sv
// coprocessor end: pipeline follower, handshake, registers and load fifo
`timescale 1ns/1ps
`default_nettype none
module cpi_fifo #(
    parameter int W = 32,
    parameter int D = 32
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    localparam logic [AW:0] FULL = (AW+1)'(D);
    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    assign in_ready = (cnt_q != FULL);
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rp_q];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_comb begin
        wp_d = push ? wp_q + 1'b1 : wp_q;
        rp_d = pop ? rp_q + 1'b1 : rp_q;
        cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            for (int i = 0; i < D; i++) begin
                mem_q[i] <= '0;
            end
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
            if (push) begin
                mem_q[wp_q] <= in_data;
            end
        end
    end
endmodule

module cpi_coproc
    import cpi_pkg::*;
#(
    parameter logic [CPN_W-1:0] CP_NUM = 4'h1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic busy,
    input wire logic [1:0] chain_dec_hs,
    input wire logic [1:0] chain_exe_hs,
    input wire logic st_valid,
    output logic st_ready,
    input wire logic [31:0] st_data,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [31:0] rd_data,
    cpi_link_if.coproc link
);
    logic pend_q, pend_d, ex_act_q, ex_act_d, ex_wait_q, ex_wait_d, ld_cap_q, ld_cap_d;
    logic [31:0] fet_q, fet_d, dec_q, dec_d, ex_q, ex_d, rdb_q, rdb_d;
    logic [CNT_W-1:0] rem_q, rem_d;
    logic [31:0] rf_q [NUM_REGS];
    logic [31:0] rf_d [NUM_REGS];
    logic adv, fifo_rdy, xstall, commit;
    cpi_hs_t own_dec, own_exe;
    cpi_op_t dop, xop;

    assign dop = op_of(dec_q);
    assign xop = op_of(ex_q);
    assign adv = pend_q & link.stall_release; // RQ2
    assign xstall = busy | ((xop == OP_LOAD) & (!fifo_rdy | ld_cap_q))
        | ((xop == OP_STORE) & !st_valid);
    assign commit = ex_act_q & link.pass & !link.abort_kill
        & ((own_exe == HS_GO) | (own_exe == HS_LAST)); // RQ9

    always_comb begin
        if ((cpn_of(dec_q) != CP_NUM) || (dop == OP_NOP) || (dop > OP_CDP)) begin
            own_dec = HS_ABSENT;
        end else if (busy) begin
            own_dec = HS_WAIT;
        end else if ((dop == OP_LOAD) || (dop == OP_STORE)) begin
            own_dec = HS_GO;
        end else begin
            own_dec = HS_LAST; // RQ21
        end
    end

    always_comb begin
        if (!ex_act_q) begin
            own_exe = HS_ABSENT;
        end else if ((xop == OP_LOAD) || (xop == OP_STORE)) begin
            own_exe = xstall ? HS_WAIT : ((rem_q > CNT_ONE) ? HS_GO : HS_LAST); // RQ11
        end else begin
            own_exe = (ex_wait_q & busy) ? HS_WAIT : HS_LAST; // RQ21
        end
    end

    always_comb begin
        pend_d = (!link.fetch_request_n & link.stall_release)
            | (pend_q & !link.stall_release); // RQ1
        fet_d = fet_q;
        dec_d = dec_q;
        ex_d = ex_q;
        ex_act_d = ex_act_q;
        ex_wait_d = ex_wait_q;
        rem_d = rem_q;
        rdb_d = rdb_q;
        ld_cap_d = 1'b0;
        st_ready = 1'b0;
        rf_d = rf_q;
        if (ex_act_q && (link.abort_kill || !link.pass)) begin
            ex_act_d = 1'b0; // RQ4 RQ5
        end else if (commit) begin // RQ10
            rem_d = rem_q - CNT_ONE;
            case (xop)
                OP_LOAD: ld_cap_d = 1'b1;
                OP_STORE: begin
                    rdb_d = st_data;
                    st_ready = 1'b1;
                end
                OP_MCR: rf_d[ra_of(ex_q)] = link.write_data_bus;
                OP_CDP: rf_d[ra_of(ex_q)] = rf_q[ra_of(ex_q)] + rf_q[rb_of(ex_q)];
                default: ;
            endcase
            if (own_exe == HS_LAST) begin
                ex_act_d = 1'b0;
            end
        end
        if (adv) begin
            fet_d = link.instruction_bus; // RQ2
            dec_d = fet_q;
            ex_d = dec_q;
            ex_act_d = (own_dec != HS_ABSENT);
            ex_wait_d = (own_dec == HS_WAIT);
            rem_d = cnt_of(dec_q);
            if (dop == OP_MRC) begin
                rdb_d = rf_q[ra_of(dec_q)]; // RQ13
            end
        end
    end

    // execute stage on the free-running core clock
    always_ff @(posedge core_clk or posedge rst) begin // RQ14
        if (rst) begin
            pend_q <= 1'b0;
            fet_q <= NOP_WORD;
            dec_q <= NOP_WORD;
            ex_q <= NOP_WORD;
            ex_act_q <= 1'b0;
            ex_wait_q <= 1'b0;
            rem_q <= '0;
            rdb_q <= NOP_WORD;
            ld_cap_q <= 1'b0;
            for (int i = 0; i < NUM_REGS; i++) begin
                rf_q[i] <= NOP_WORD;
            end
        end else begin
            pend_q <= pend_d;
            fet_q <= fet_d;
            dec_q <= dec_d;
            ex_q <= ex_d;
            ex_act_q <= ex_act_d;
            ex_wait_q <= ex_wait_d;
            rem_q <= rem_d;
            rdb_q <= rdb_d;
            ld_cap_q <= ld_cap_d;
            rf_q <= rf_d;
        end
    end

    cpi_fifo #(
        .W(DATA_W),
        .D(FIFO_DEPTH)
    ) u_load_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .in_valid(ld_cap_q),
        .in_ready(fifo_rdy),
        .in_data(link.write_data_bus),
        .out_valid(rd_valid),
        .out_ready(rd_ready),
        .out_data(rd_data)
    );

    assign link.decode_handshake = hs_merge(own_dec, chain_dec_hs); // RQ16 RQ17
    assign link.execute_handshake = hs_merge(own_exe, chain_exe_hs); // RQ16 RQ17
    assign link.read_data_bus = rdb_q;
endmodule
`default_nettype wire

// >>> logic/cpi_core.sv
// core end of the coprocessor handshake port
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RQ1: fetch seen on release high, request low
// RQ2: follower advances only on each seen fetch
// RQ3: pass high for passing coprocessor instruction
// RQ4: busy-wait keeps pass; interrupt drops it
// RQ5: abort kill only after first execute cycle
// RQ6: sample decode handshake entering execute, else execute
// RQ7: absent handshake takes undefined instruction trap
// RQ8: wait stalls until handshake changes or interrupt
// RQ9: coprocessor commits only on pass with go/last
// RQ10: go needs another cycle; pass still required
// RQ11: go while two or more words remain, last otherwise
// RQ12: transfer address and data request in execute
// RQ13: coprocessor owns read bus after execute entry
// RQ14: coprocessor execute runs on ungated core clock
// RQ15: absent 10, wait 00, go 01, last 11
// RQ16: unattached handshake inputs tied to absent
// RQ17: merge buses: AND bit one, OR bit zero
// RQ18: decode handshake used only when condition passes
// RQ19: last commits move; write bus or read sample
// RQ20: move waits in decode until data available
// RQ21: data op answers last, or wait then last
module cpi_core
    import cpi_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [31:0] cmd_word,
    input wire logic cmd_cond_ok,
    input wire logic [31:0] cmd_wdata,
    input wire logic [31:0] cmd_addr,
    input wire logic data_avail,
    input wire logic prev_abort,
    input wire logic irq,
    input wire logic stall_in,
    output logic [31:0] mem_addr,
    input wire logic [31:0] mem_rdata,
    output logic [31:0] st_data,
    output logic st_valid,
    output logic [31:0] mrc_data,
    output logic done,
    output logic undef,
    output logic cancelled,
    output logic abandoned,
    cpi_link_if.core link
);
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_F1 = 8'h02,
        ST_F2 = 8'h04,
        ST_PAD = 8'h08,
        ST_DEC = 8'h10,
        ST_EX1 = 8'h20,
        ST_EXEC = 8'h40,
        ST_MEM = 8'h80
    } cpi_core_state_t;

    cpi_core_state_t st_q, st_d;
    logic [31:0] word_q, word_d, ibus_q, ibus_d, wbus_q, wbus_d;
    logic [31:0] addr_q, addr_d, sdat_q, sdat_d, mrc_q, mrc_d;
    logic cond_q, cond_d, kill_q, kill_d, first_q, first_d;
    logic lastd_q, lastd_d, spend_q, spend_d, sval_q, sval_d;
    logic done_q, done_d, undef_q, undef_d, canc_q, canc_d, aband_q, aband_d;
    logic fetch_n, pass_c, dreq_n, kill_now, is_ldst;
    cpi_op_t op;
    cpi_hs_t dhs, ehs;

    assign op = op_of(word_q);
    assign dhs = link.decode_handshake;
    assign ehs = link.execute_handshake;
    assign is_ldst = (op == OP_LOAD) || (op == OP_STORE);
    assign kill_now = kill_q & first_q;

    always_comb begin
        st_d = st_q;
        word_d = word_q;
        cond_d = cond_q;
        ibus_d = ibus_q;
        wbus_d = wbus_q;
        addr_d = addr_q;
        kill_d = kill_q;
        lastd_d = lastd_q;
        mrc_d = mrc_q;
        sdat_d = sdat_q;
        first_d = 1'b0;
        spend_d = 1'b0;
        sval_d = 1'b0;
        done_d = 1'b0;
        undef_d = 1'b0;
        canc_d = 1'b0;
        aband_d = 1'b0;
        fetch_n = 1'b1;
        pass_c = 1'b0;
        dreq_n = 1'b1;
        // store word comes back on the read bus one cycle after transfer
        if (spend_q) begin
            sdat_d = link.read_data_bus;
            sval_d = 1'b1;
        end
        case (st_q)
            ST_IDLE: begin
                if (cmd_valid) begin
                    word_d = cmd_word;
                    cond_d = cmd_cond_ok;
                    addr_d = cmd_addr;
                    st_d = ST_F1;
                end
            end
            ST_F1: begin
                fetch_n = 1'b0; // RQ1
                if (stall_in) begin
                    ibus_d = word_q; // RQ1
                    st_d = ST_F2;
                end
            end
            ST_F2: begin
                fetch_n = 1'b0;
                if (stall_in) begin
                    ibus_d = NOP_WORD;
                    st_d = ST_PAD;
                end
            end
            ST_PAD: begin
                if (stall_in) begin
                    st_d = ST_DEC;
                end
            end
            ST_DEC: begin
                if (!((op == OP_MCR) && !data_avail)) begin // RQ20
                    fetch_n = 1'b0;
                    pass_c = cond_q; // RQ3
                    if (stall_in) begin
                        ibus_d = NOP_WORD;
                        kill_d = prev_abort;
                        if (!cond_q) begin
                            done_d = 1'b1; // RQ18
                            st_d = ST_IDLE;
                        end else if (dhs == HS_ABSENT) begin // RQ6 RQ15
                            undef_d = 1'b1; // RQ7
                            st_d = ST_IDLE;
                        end else begin
                            if (op == OP_MCR) begin
                                wbus_d = cmd_wdata; // RQ19
                            end
                            lastd_d = (dhs == HS_LAST) && !is_ldst; // RQ21
                            st_d = ST_EX1;
                        end
                    end
                end
            end
            ST_EX1: begin
                pass_c = 1'b1; // RQ3
                if (stall_in) begin
                    first_d = 1'b1;
                    st_d = lastd_q ? ST_MEM : ST_EXEC;
                end
            end
            ST_EXEC: begin
                pass_c = !(irq && (ehs == HS_WAIT)); // RQ4
                if (kill_now) begin
                    canc_d = 1'b1; // RQ5
                    st_d = ST_IDLE;
                end else if (ehs == HS_ABSENT) begin // RQ6
                    undef_d = 1'b1; // RQ7
                    st_d = ST_IDLE;
                end else if (ehs == HS_WAIT) begin
                    if (irq) begin
                        aband_d = 1'b1; // RQ8
                        st_d = ST_IDLE;
                    end
                end else begin
                    if (is_ldst) begin
                        dreq_n = 1'b0; // RQ12
                        addr_d = addr_q + WORD_STEP;
                        spend_d = (op == OP_STORE);
                        if (op == OP_LOAD) begin
                            wbus_d = mem_rdata;
                        end
                    end
                    if (ehs == HS_LAST) begin // RQ10
                        if (op == OP_MRC) begin
                            st_d = ST_MEM;
                        end else begin
                            done_d = 1'b1; // RQ19
                            st_d = ST_IDLE;
                        end
                    end
                end
            end
            ST_MEM: begin
                pass_c = 1'b1; // RQ21
                if (kill_now) begin
                    canc_d = 1'b1; // RQ5
                end else begin
                    done_d = 1'b1;
                    if (op == OP_MRC) begin
                        mrc_d = link.read_data_bus; // RQ19
                    end
                end
                st_d = ST_IDLE;
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_q <= ST_IDLE;
            word_q <= NOP_WORD;
            cond_q <= 1'b0;
            ibus_q <= NOP_WORD;
            wbus_q <= NOP_WORD;
            addr_q <= NOP_WORD;
            kill_q <= 1'b0;
            lastd_q <= 1'b0;
            mrc_q <= NOP_WORD;
            sdat_q <= NOP_WORD;
            first_q <= 1'b0;
            spend_q <= 1'b0;
            sval_q <= 1'b0;
            done_q <= 1'b0;
            undef_q <= 1'b0;
            canc_q <= 1'b0;
            aband_q <= 1'b0;
        end else begin
            st_q <= st_d;
            word_q <= word_d;
            cond_q <= cond_d;
            ibus_q <= ibus_d;
            wbus_q <= wbus_d;
            addr_q <= addr_d;
            kill_q <= kill_d;
            lastd_q <= lastd_d;
            mrc_q <= mrc_d;
            sdat_q <= sdat_d;
            first_q <= first_d;
            spend_q <= spend_d;
            sval_q <= sval_d;
            done_q <= done_d;
            undef_q <= undef_d;
            canc_q <= canc_d;
            aband_q <= aband_d;
        end
    end

    assign cmd_ready = (st_q == ST_IDLE);
    assign mem_addr = addr_q;
    assign st_data = sdat_q;
    assign st_valid = sval_q;
    assign mrc_data = mrc_q;
    assign done = done_q;
    assign undef = undef_q;
    assign cancelled = canc_q;
    assign abandoned = aband_q;
    assign link.fetch_request_n = fetch_n;
    assign link.stall_release = stall_in;
    assign link.instruction_bus = ibus_q;
    assign link.pass = pass_c;
    assign link.abort_kill = kill_now && ((st_q == ST_EXEC) || (st_q == ST_MEM)); // RQ5
    assign link.data_request_n = dreq_n;
    assign link.write_data_bus = wbus_q;
endmodule
`default_nettype wire

// >>> verification/coprocessor_handshake_port_test.sv
// self-checking bench of the coprocessor handshake port, both ends joined
`timescale 1ns/1ps
`default_nettype none
module coprocessor_handshake_port_test
    import cpi_pkg::*;
;
    logic core_clk = 1'h0, rst = 1'h1, cmd_valid = 1'h0, cmd_cond_ok = 1'h1;
    logic data_avail = 1'h1, prev_abort = 1'h0, irq = 1'h0, stall_in = 1'h1;
    logic busy = 1'h0, rd_ready = 1'h0, cp_st_valid = 1'h1;
    logic [31:0] cmd_word = 32'h0, cmd_wdata = 32'h0, cmd_addr = 32'h0;
    logic [31:0] sidx = 32'h0;
    logic [1:0] chain_dec_hs = HS_ABSENT, chain_exe_hs = HS_ABSENT;
    logic cmd_ready, st_valid, done, undef, cancelled, abandoned;
    logic cp_st_ready, rd_valid;
    logic [31:0] mem_addr, st_data, mrc_data, rd_data;
    wire logic [31:0] mem_rdata;
    wire logic [31:0] cp_st_data;
    logic [31:0] stq[$];
    int n_fail = 0, tests_run = 0, lock_n = 0, stall_n = 0, irq_n = 999, busy_n = 0;
    localparam logic [3:0] CP = 4'h1;
    assign mem_rdata = mem_addr ^ 32'h5A5A_5A5A;
    assign cp_st_data = 32'h5E00_0000 | sidx;
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (cp_st_ready === 1'h1) begin
            sidx <= sidx + 32'h1;
        end
        if (st_valid === 1'h1) begin
            stq.push_back(st_data);
        end
    end
    cpi_link_if lk ();
    cpi_core cpi_core_i (
        .core_clk, .rst, .cmd_valid, .cmd_ready, .cmd_word, .cmd_cond_ok, .cmd_wdata,
        .cmd_addr, .data_avail, .prev_abort, .irq, .stall_in, .mem_addr, .mem_rdata,
        .st_data, .st_valid, .mrc_data, .done, .undef, .cancelled, .abandoned, .link(lk)
    );
    cpi_coproc #(.CP_NUM(CP)) cpi_coproc_i (
        .core_clk, .rst, .busy, .chain_dec_hs, .chain_exe_hs, .st_valid(cp_st_valid),
        .st_ready(cp_st_ready), .st_data(cp_st_data), .rd_valid, .rd_ready, .rd_data,
        .link(lk)
    );
    cpi_link_asserts cpi_link_asserts_i (
        .core_clk, .rst, .fetch_request_n(lk.fetch_request_n),
        .stall_release(lk.stall_release), .instruction_bus(lk.instruction_bus),
        .pass(lk.pass), .abort_kill(lk.abort_kill), .data_request_n(lk.data_request_n),
        .write_data_bus(lk.write_data_bus), .decode_handshake(lk.decode_handshake),
        .execute_handshake(lk.execute_handshake), .read_data_bus(lk.read_data_bus)
    );
    function automatic logic [31:0] mk(input cpi_op_t op, input logic [3:0] n,
                                       input logic [3:0] cnt, input logic [1:0] a);
        return {1'h0, op, 16'h0, n, cnt, 2'h1, a};
    endfunction
    task automatic chk_end(input logic [1:0] got, input logic [1:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected end code at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic issue(input logic [31:0] w, input logic c, input logic [31:0] d,
                         input logic ab, input logic [1:0] exp);
        int k;
        logic [1:0] got;
        k = 0;
        got = 2'hx;
        cmd_word = w;
        cmd_cond_ok = c;
        cmd_wdata = d;
        prev_abort = ab;
        busy = busy_n > 0;
        data_avail = lock_n == 0;
        cmd_valid = 1'h1;
        @(posedge core_clk);
        #1;
        cmd_valid = 1'h0;
        while (k < 300 && {done, undef, cancelled, abandoned} === 4'h0) begin
            k++;
            data_avail = k >= lock_n;
            stall_in = k >= stall_n;
            irq = k >= irq_n;
            busy = k < busy_n;
            @(posedge core_clk);
            #1;
        end
        if (done === 1'h1) got = 2'h0;
        else if (undef === 1'h1) got = 2'h1;
        else if (cancelled === 1'h1) got = 2'h2;
        else if (abandoned === 1'h1) got = 2'h3;
        chk_end(got, exp);
        {prev_abort, irq, busy, data_avail, stall_in} = 5'h3;
        lock_n = 0;
        stall_n = 0;
        irq_n = 999;
        busy_n = 0;
    endtask
    task automatic rd_reg(input logic [1:0] a, input logic [31:0] exp);
        issue(mk(OP_MRC, CP, 4'h1, a), 1'h1, 32'h0, 1'h0, 2'h0);
        chk_word(mrc_data, exp);
    endtask
    task automatic drain(input logic [31:0] base, input int n);
        for (int i = 0; i < n; i++) begin
            for (int k = 0; k < 20 && rd_valid !== 1'h1; k++) begin
                @(posedge core_clk);
                #1;
            end
            chk_word(rd_data, (base + 32'(i) * 32'h4) ^ 32'h5A5A_5A5A);
            rd_ready = 1'h1;
            @(posedge core_clk);
            #1;
            rd_ready = 1'h0;
        end
        chk_word({31'h0, rd_valid}, 32'h0);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #200000;
        n_fail++;
        results();
    end
    initial begin
        repeat (16) @(posedge core_clk);
        #1;
        rst = 1'h0;
        stall_n = 4;
        issue(mk(OP_MCR, CP, 4'h1, 2'h1), 1'h1, 32'hA5A5_0001, 1'h0, 2'h0);
        lock_n = 5;
        issue(mk(OP_MCR, CP, 4'h1, 2'h2), 1'h1, 32'h0000_0010, 1'h0, 2'h0);
        rd_reg(2'h1, 32'hA5A5_0001);
        issue(mk(OP_CDP, CP, 4'h1, 2'h2), 1'h1, 32'h0, 1'h0, 2'h0);
        rd_reg(2'h2, 32'hA5A5_0011);
        $display("test moves and data op ended");
        issue(mk(OP_MCR, CP, 4'h1, 2'h1), 1'h0, 32'hFFFF_FFFF, 1'h0, 2'h0);
        rd_reg(2'h1, 32'hA5A5_0001);
        issue(mk(OP_CDP, CP, 4'h1, 2'h2), 1'h1, 32'h0, 1'h1, 2'h2);
        rd_reg(2'h2, 32'hA5A5_0011);
        $display("test failed condition and late cancel ended");
        issue(mk(OP_MCR, 4'h2, 4'h1, 2'h1), 1'h1, 32'h1, 1'h0, 2'h1);
        {chain_dec_hs, chain_exe_hs} = {HS_LAST, HS_LAST};
        issue(mk(OP_CDP, 4'h2, 4'h1, 2'h1), 1'h1, 32'h0, 1'h0, 2'h0);
        {chain_dec_hs, chain_exe_hs} = {HS_ABSENT, HS_ABSENT};
        rd_reg(2'h1, 32'hA5A5_0001);
        $display("test absent and merged handshake ended");
        busy_n = 6;
        issue(mk(OP_CDP, CP, 4'h1, 2'h1), 1'h1, 32'h0, 1'h0, 2'h0);
        rd_reg(2'h1, 32'h4B4A_0002);
        busy_n = 60;
        irq_n = 12;
        issue(mk(OP_CDP, CP, 4'h1, 2'h1), 1'h1, 32'h0, 1'h0, 2'h3);
        rd_reg(2'h1, 32'h4B4A_0002);
        $display("test busy wait ended");
        cmd_addr = 32'h0000_1000;
        issue(mk(OP_LOAD, CP, 4'h4, 2'h0), 1'h1, 32'h0, 1'h0, 2'h0);
        drain(32'h1000, 4);
        issue(mk(OP_STORE, CP, 4'h2, 2'h0), 1'h1, 32'h0, 1'h0, 2'h0);
        repeat (3) @(posedge core_clk);
        #1;
        chk_word(32'(stq.size()), 32'h2);
        chk_word(stq[0], 32'h5E00_0000);
        chk_word(stq[1], 32'h5E00_0001);
        $display("test load and store ended");
        for (int j = 0; j < 3; j++) begin
            cmd_addr = 32'h2000 + 32'(j) * 32'h3C;
            issue(mk(OP_LOAD, CP, j < 2 ? 4'hF : 4'h2, 2'h0), 1'h1, 32'h0, 1'h0, 2'h0);
        end
        drain(32'h2000, FIFO_DEPTH);
        $display("test fifo fill and drain ended");
        results();
    end
endmodule
`default_nettype wire

// >>> verification/cpi_link_asserts.sv
// concurrent checks on the link between core end and coprocessor end
`timescale 1ns/1ps
`default_nettype none
module cpi_link_asserts
    import cpi_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic fetch_request_n,
    input wire logic stall_release,
    input wire logic [31:0] instruction_bus,
    input wire logic pass,
    input wire logic abort_kill,
    input wire logic data_request_n,
    input wire logic [31:0] write_data_bus,
    input wire logic [1:0] decode_handshake,
    input wire logic [1:0] execute_handshake,
    input wire logic [31:0] read_data_bus
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    sequence s_idle_fetch;
        fetch_request_n || !stall_release;
    endsequence
    sequence s_xfer;
        !data_request_n;
    endsequence
    sequence s_kill;
        pass ##1 abort_kill;
    endsequence
    chk_kill_after_pass: assert property (abort_kill |-> $past(pass))
        else $error("abort kill without pass in the cycle before");
    chk_kill_with_pass: assert property (abort_kill |-> pass)
        else $error("abort kill while pass is low");
    chk_kill_one_cycle: assert property (s_kill |=> !abort_kill)
        else $error("abort kill held longer than one cycle");
    chk_ibus_hold: assert property (
        s_idle_fetch |=> $stable(instruction_bus))
        else $error("instruction bus moved without a fetch");
    chk_req_on_go: assert property (
        s_xfer |-> execute_handshake[HS_OR_BIT])
        else $error("data request without go or last");
    chk_req_with_pass: assert property (s_xfer |-> pass)
        else $error("data request while pass is low");
    chk_rdata_after_pass: assert property (
        $changed(read_data_bus) |-> $past(pass))
        else $error("read data bus changed without pass");
    chk_wdata_on_xfer: assert property (
        $changed(write_data_bus) |-> !$past(data_request_n) || $past(pass))
        else $error("write data bus changed outside a transfer");
endmodule
`default_nettype wire
